//--- rtl/sdf_pkg.sv
package sdf_pkg;
   // ------------------------------------------------------------
   // Frame timing
   // ------------------------------------------------------------
   localparam int unsigned SAMPLES_PER_FRAME = 128;
   localparam logic [6:0] SAMPLE_CNT_LAST = 7'h7F;
   localparam int unsigned FWD_PACKETS_PER_FRAME = 4;
   localparam int unsigned FWD_BYTES_PER_PACKET = 1;
   localparam int unsigned RET_PACKETS_PER_FRAME = 1;
   localparam int unsigned RET_BYTES_PER_PACKET = 5;
   localparam logic [1:0] FWD_SLOT_LAST = 2'h3;
   localparam logic [2:0] RET_SLOT_LAST = 3'h4;
   // Fraction of a frame between forward slots, in sample periods
   localparam logic [6:0] FWD_SLOT_SPACING = 7'h20;

   // ------------------------------------------------------------
   // Sample rates, in hertz, and their fractional NCO increments
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned RATE_48K_HZ = 48000;
   localparam int unsigned RATE_44K1_HZ = 44100;
   localparam int unsigned RATE_32K_HZ = 32000;
   localparam int unsigned NCO_BITS = 24;
   localparam logic [23:0] NCO_INC_48K = 24'((64'(RATE_48K_HZ) << NCO_BITS) / CLK_HZ);
   localparam logic [23:0] NCO_INC_44K1 = 24'((64'(RATE_44K1_HZ) << NCO_BITS) / CLK_HZ);
   localparam logic [23:0] NCO_INC_32K = 24'((64'(RATE_32K_HZ) << NCO_BITS) / CLK_HZ);

   typedef enum logic [1:0] {
      SDF_RATE_48K = 2'h0,
      SDF_RATE_44K1 = 2'h1,
      SDF_RATE_32K = 2'h2
   } sdf_rate_e;

   // ------------------------------------------------------------
   // Return slot traffic classes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SDF_RC_LINK_ERR = 2'h0,
      SDF_RC_PIN_STATE = 2'h1,
      SDF_RC_MASTER = 2'h2,
      SDF_RC_IDLE = 2'h3
   } sdf_class_e;

   // ------------------------------------------------------------
   // Link engine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SDF_LK_SEARCH = 2'b00,
      SDF_LK_SYNC = 2'b01,
      SDF_LK_UP = 2'b11
   } sdf_link_e;
   localparam logic [3:0] LOSS_LIMIT = 4'h8;
   localparam logic [3:0] SYNC_FRAMES = 4'h3;
   localparam logic [3:0] CHAN_FAIL_LIMIT = 4'h4;
   localparam logic [1:0] RETRY_LIMIT = 2'h2;
   localparam int unsigned CHAN_COUNT = 38;
   localparam logic [5:0] CHAN_LAST = 6'h25;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sdf_byte_s;

   typedef struct packed {
      logic valid;
      logic [5:0] seq;
      logic ok;
   } sdf_audio_s;
endpackage

//--- rtl/sdf_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sdf_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH_LOG2 = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned DEPTH = 1 << DEPTH_LOG2;

   typedef struct packed {
      logic [DEPTH_LOG2:0] wr_ptr;
      logic [DEPTH_LOG2:0] rd_ptr;
   } sdf_fifo_s;

   logic [WIDTH-1:0] mem [DEPTH];
   sdf_fifo_s st_reg;
   sdf_fifo_s st_next;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (st_reg.wr_ptr[DEPTH_LOG2] != st_reg.rd_ptr[DEPTH_LOG2]) &&
                 (st_reg.wr_ptr[DEPTH_LOG2-1:0] == st_reg.rd_ptr[DEPTH_LOG2-1:0]);
   assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[st_reg.rd_ptr[DEPTH_LOG2-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_reg.wr_ptr[DEPTH_LOG2-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

//--- rtl/sdf_framer.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - A side data frame starts every 128 audio sample periods.
// - Forward frames carry four one-byte packets inside the audio stream.
// - Frame timing follows the active 48, 44.1 or 32 kSPS rate.
// - All local sources share one FIFO feeding the forward channel.
// - Return direction carries one five-byte packet per frame in the acknowledge.
// - Return capacity splits among link error, pin state and master traffic.
// - Link error report gets one return byte every frame.
// - Pin state gets one return byte every second frame.
// - Serial master traffic gets one return byte every frame.
// - Bad or missing audio packets are detected and resent.
// - Conceal audio when resending fails within the latency window.
// - Channels with repeated failures are flagged in CHAN_BANNED; the channel hop still visits them.
// - A lost link is re-established automatically.
// - Link setup runs fully in hardware with no adjustable steps.
// - Link status travels over the control channel between devices.
module sdf_framer #(
   parameter int unsigned SRC_COUNT = 2,
   parameter int unsigned FIFO_DEPTH_LOG2 = 4
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic AUDIO_TRANSMITTER_MODE,
   input wire sdf_pkg::sdf_rate_e AUDIO_FUNDAMENTAL_RATE,
   input wire logic [SRC_COUNT-1:0] SRC_VALID,
   input wire logic [SRC_COUNT*8-1:0] SRC_DATA,
   output logic [SRC_COUNT-1:0] SRC_READY,
   output sdf_pkg::sdf_byte_s FWD_SLOT,
   output logic FRAME_START,
   input wire sdf_pkg::sdf_byte_s LINK_ERR_IN,
   input wire logic [3:0] PIN_STATE_IN,
   input wire sdf_pkg::sdf_byte_s MASTER_IN,
   output logic MASTER_READY,
   output sdf_pkg::sdf_byte_s RET_SLOT,
   output sdf_pkg::sdf_class_e RET_CLASS,
   input wire sdf_pkg::sdf_audio_s AUDIO_RX,
   output logic RESEND_REQ,
   output logic [5:0] RESEND_SEQ,
   output logic CONCEAL,
   output logic [5:0] CHANNEL,
   output logic [sdf_pkg::CHAN_COUNT-1:0] CHAN_BANNED,
   output logic LINK_UP,
   output logic RELINK
);
   import sdf_pkg::*;

   typedef struct packed {
      logic [23:0] nco;
      logic [6:0] sample_cnt;
      logic pin_turn;
      logic [2:0] ret_idx;
      logic [1:0] fwd_idx;
      logic [SRC_COUNT-1:0] rr;
      sdf_byte_s fwd_slot;
      logic frame_start;
      sdf_byte_s ret_slot;
      sdf_class_e ret_class;
      logic master_ready;
      sdf_link_e link;
      logic [3:0] loss_cnt;
      logic [3:0] sync_cnt;
      logic [5:0] exp_seq;
      logic [1:0] retry;
      logic resend;
      logic [5:0] resend_seq;
      logic conceal;
      logic [5:0] chan;
      logic [3:0] chan_fail;
      logic [CHAN_COUNT-1:0] banned;
      logic relink;
      logic link_up;
   } sdf_state_s;

   sdf_state_s st_reg;
   sdf_state_s st_next;
   logic sample_tick;
   logic [24:0] nco_sum;
   logic [23:0] nco_inc;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic [SRC_COUNT-1:0] grant;
   logic fwd_slot_due;

   // ------------------------------------------------------------
   // Sample rate enable
   // ------------------------------------------------------------
   always_comb begin
      unique case (AUDIO_FUNDAMENTAL_RATE)
         SDF_RATE_44K1: nco_inc = NCO_INC_44K1;
         SDF_RATE_32K: nco_inc = NCO_INC_32K;
         default: nco_inc = NCO_INC_48K;
      endcase
   end
   assign nco_sum = {1'b0, st_reg.nco} + {1'b0, nco_inc};
   assign sample_tick = nco_sum[NCO_BITS];

   // ------------------------------------------------------------
   // Source arbitration into the shared queue
   // ------------------------------------------------------------
   always_comb begin
      grant = '0;
      for (int i = 0; i < SRC_COUNT; i++) begin
         if (grant == '0 && SRC_VALID[(int'(st_reg.rr) + i) % SRC_COUNT] != 1'b0) begin
            grant[(int'(st_reg.rr) + i) % SRC_COUNT] = 1'b1;
         end
      end
   end

   always_comb begin
      fifo_in_data = '0;
      for (int i = 0; i < SRC_COUNT; i++) begin
         if (grant[i]) begin
            fifo_in_data = SRC_DATA[i*8 +: 8];
         end
      end
   end
   assign fifo_in_valid = |grant;

   genvar g;
   generate
      for (g = 0; g < SRC_COUNT; g++) begin : g_ready
         assign SRC_READY[g] = grant[g] && fifo_in_ready;
      end
   endgenerate

   assign fwd_slot_due = sample_tick && AUDIO_TRANSMITTER_MODE &&
                         (st_reg.sample_cnt[4:0] == FWD_SLOT_SPACING[4:0]);
   assign fifo_out_ready = fwd_slot_due;

   sdf_fifo #(
      .WIDTH(8),
      .DEPTH_LOG2(FIFO_DEPTH_LOG2)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.nco = nco_sum[NCO_BITS-1:0];
      st_next.frame_start = 1'b0;
      st_next.fwd_slot.valid = 1'b0;
      st_next.ret_slot.valid = 1'b0;
      st_next.master_ready = 1'b0;
      st_next.resend = 1'b0;
      st_next.relink = 1'b0;
      if (fifo_in_valid && fifo_in_ready) begin
         st_next.rr = (st_reg.rr == SRC_COUNT[SRC_COUNT-1:0] - 1'b1) ? '0 : st_reg.rr + 1'b1;
      end
      if (sample_tick) begin
         st_next.sample_cnt = st_reg.sample_cnt + 1'b1;
         if (st_reg.sample_cnt == SAMPLE_CNT_LAST) begin
            st_next.frame_start = 1'b1;
            st_next.ret_idx = '0;
            st_next.fwd_idx = '0;
            st_next.pin_turn = !st_reg.pin_turn;
         end
         // Four forward slots evenly spaced through the frame
         if (fwd_slot_due) begin
            st_next.fwd_slot.valid = fifo_out_valid;
            st_next.fwd_slot.data = fifo_out_valid ? fifo_out_data : 8'h00;
            st_next.fwd_idx = st_reg.fwd_idx + 1'b1;
         end
         // Return packet: five byte slots in the acknowledge, receiver only
         if (!AUDIO_TRANSMITTER_MODE && st_reg.ret_idx <= RET_SLOT_LAST && st_reg.sample_cnt[0]) begin
            st_next.ret_idx = st_reg.ret_idx + 1'b1;
            st_next.ret_slot.valid = 1'b1;
            unique case (st_reg.ret_idx)
               3'h0: begin
                  st_next.ret_class = SDF_RC_LINK_ERR;
                  st_next.ret_slot.data = LINK_ERR_IN.valid ? LINK_ERR_IN.data :
                                          {4'h0, st_reg.loss_cnt};
               end
               3'h1: begin
                  st_next.ret_class = st_reg.pin_turn ? SDF_RC_PIN_STATE : SDF_RC_IDLE;
                  st_next.ret_slot.data = st_reg.pin_turn ? {4'h0, PIN_STATE_IN} : 8'h00;
               end
               3'h2: begin
                  st_next.ret_class = MASTER_IN.valid ? SDF_RC_MASTER : SDF_RC_IDLE;
                  st_next.ret_slot.data = MASTER_IN.valid ? MASTER_IN.data : 8'h00;
                  st_next.master_ready = MASTER_IN.valid;
               end
               default: begin
                  st_next.ret_class = SDF_RC_IDLE;
                  st_next.ret_slot.data = 8'h00;
               end
            endcase
         end
      end

      // Link engine, sequence check and channel policing; a good packet while searching only syncs
      if (AUDIO_RX.valid && !(st_reg.link == SDF_LK_SEARCH && AUDIO_RX.ok)) begin
         if (AUDIO_RX.ok && AUDIO_RX.seq == st_reg.exp_seq) begin
            st_next.exp_seq = st_reg.exp_seq + 1'b1;
            st_next.retry = '0;
            st_next.conceal = 1'b0;
            st_next.loss_cnt = '0;
            st_next.chan_fail = '0;
         end else begin
            st_next.loss_cnt = (st_reg.loss_cnt == LOSS_LIMIT) ? st_reg.loss_cnt : st_reg.loss_cnt + 1'b1;
            st_next.chan_fail = st_reg.chan_fail + 1'b1;
            if (st_reg.retry == RETRY_LIMIT) begin
               st_next.conceal = 1'b1;
               st_next.exp_seq = st_reg.exp_seq + 1'b1;
               st_next.retry = '0;
            end else begin
               st_next.resend = 1'b1;
               st_next.resend_seq = st_reg.exp_seq;
               st_next.retry = st_reg.retry + 1'b1;
            end
            if (st_reg.chan_fail == CHAN_FAIL_LIMIT - 1'b1) begin
               st_next.banned[st_reg.chan] = 1'b1;
               st_next.chan_fail = '0;
            end
         end
      end
      if (st_next.chan != st_reg.chan || st_next.banned != st_reg.banned || st_next.frame_start) begin
         st_next.chan = (st_reg.chan == CHAN_LAST) ? '0 : st_reg.chan + 1'b1;
         if (&st_next.banned) begin
            st_next.banned = '0;
         end
      end

      unique case (st_reg.link)
         SDF_LK_SEARCH: begin
            if (AUDIO_RX.valid && AUDIO_RX.ok) begin
               st_next.link = SDF_LK_SYNC;
               st_next.sync_cnt = '0;
               st_next.exp_seq = AUDIO_RX.seq + 1'b1;
            end
         end
         SDF_LK_SYNC: begin
            if (st_next.loss_cnt != '0) begin
               st_next.link = SDF_LK_SEARCH;
            end else if (st_reg.frame_start) begin
               st_next.sync_cnt = st_reg.sync_cnt + 1'b1;
               if (st_reg.sync_cnt == SYNC_FRAMES) begin
                  st_next.link = SDF_LK_UP;
               end
            end
         end
         SDF_LK_UP: begin
            if (st_reg.loss_cnt == LOSS_LIMIT) begin
               st_next.link = SDF_LK_SEARCH;
               st_next.relink = 1'b1;
               st_next.loss_cnt = '0;
            end
         end
         default: st_next.link = SDF_LK_SEARCH;
      endcase
      st_next.link_up = st_next.link == SDF_LK_UP;
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign FWD_SLOT = st_reg.fwd_slot;
   assign FRAME_START = st_reg.frame_start;
   assign RET_SLOT = st_reg.ret_slot;
   assign RET_CLASS = st_reg.ret_class;
   assign MASTER_READY = st_reg.master_ready;
   assign RESEND_REQ = st_reg.resend;
   assign RESEND_SEQ = st_reg.resend_seq;
   assign CONCEAL = st_reg.conceal;
   assign CHANNEL = st_reg.chan;
   assign CHAN_BANNED = st_reg.banned;
   assign LINK_UP = st_reg.link_up;
   assign RELINK = st_reg.relink;
endmodule
`default_nettype wire

//--- dv/sdf_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sdf_peer
   import sdf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic send,
   input wire logic [5:0] seq,
   input wire logic ok,
   input wire logic [3:0] lag,
   output sdf_pkg::sdf_audio_s audio_rx
);
   logic busy_reg;
   logic [3:0] wait_reg;
   sdf_audio_s pend_reg;
   // ----
   // Audio packet source, held back lag cycles
   // ----
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
         wait_reg <= 4'h0;
         pend_reg <= 8'h0;
         audio_rx <= 8'h0;
      end else begin
         // Idle fields toggle so nothing can lean on stale values
         audio_rx <= {1'b0, ~audio_rx.seq, ~audio_rx.ok};
         if (send) begin
            busy_reg <= 1'b1;
            wait_reg <= lag;
            pend_reg <= {1'b1, seq, ok};
         end else if (busy_reg && wait_reg == 4'h0) begin
            audio_rx <= pend_reg;
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/sdf_framer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sdf_framer_chk
   import sdf_pkg::*;
#(
   parameter int unsigned SRC_COUNT = 2,
   parameter int unsigned FIFO_DEPTH_LOG2 = 4
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic AUDIO_TRANSMITTER_MODE,
   input wire sdf_pkg::sdf_rate_e AUDIO_FUNDAMENTAL_RATE,
   input wire logic [SRC_COUNT-1:0] SRC_VALID,
   input wire logic [SRC_COUNT*8-1:0] SRC_DATA,
   input wire logic [SRC_COUNT-1:0] SRC_READY,
   input wire sdf_pkg::sdf_byte_s FWD_SLOT,
   input wire logic FRAME_START,
   input wire sdf_pkg::sdf_byte_s LINK_ERR_IN,
   input wire logic [3:0] PIN_STATE_IN,
   input wire sdf_pkg::sdf_byte_s MASTER_IN,
   input wire logic MASTER_READY,
   input wire sdf_pkg::sdf_byte_s RET_SLOT,
   input wire sdf_pkg::sdf_class_e RET_CLASS,
   input wire sdf_pkg::sdf_audio_s AUDIO_RX,
   input wire logic RESEND_REQ,
   input wire logic [5:0] RESEND_SEQ,
   input wire logic CONCEAL,
   input wire logic [5:0] CHANNEL,
   input wire logic [sdf_pkg::CHAN_COUNT-1:0] CHAN_BANNED,
   input wire logic LINK_UP,
   input wire logic RELINK
);
   // ----
   // Frame gap counter and bad packet run
   // ----
   logic [16:0] gap_reg;
   logic seen_reg;
   logic [2:0] run_reg;
   logic [5:0] bad_reg;
   logic bad_d_reg;
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         gap_reg <= 17'h0;
         seen_reg <= 1'b0;
         run_reg <= 3'h0;
         bad_reg <= 6'h0;
         bad_d_reg <= 1'b0;
      end else begin
         // Expected sequence: next after a good packet, skipped past a bad one that drew no resend
         bad_d_reg <= AUDIO_RX.valid && !AUDIO_RX.ok;
         gap_reg <= FRAME_START ? 17'h1 : gap_reg + 17'(gap_reg != 17'h1FFFF);
         seen_reg <= seen_reg | FRAME_START;
         if (AUDIO_RX.valid) run_reg <= AUDIO_RX.ok ? 3'h0 : run_reg + 3'(run_reg != 3'h7);
         if (AUDIO_RX.valid && AUDIO_RX.ok) bad_reg <= AUDIO_RX.seq + 6'h1;
         else if (bad_d_reg && !RESEND_REQ) bad_reg <= bad_reg + 6'h1;
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   sequence fwd_quiet;
      !FWD_SLOT.valid [*8];
   endsequence
   sequence resend_once;
      RESEND_SEQ == bad_reg ##1 !RESEND_REQ;
   endsequence
   chk_slot_pulse: assert property (FWD_SLOT.valid |=> fwd_quiet) else $error("slot too long");
   chk_fwd_txonly: assert property (!AUDIO_TRANSMITTER_MODE && !$past(AUDIO_TRANSMITTER_MODE) |->
      !FWD_SLOT.valid) else $error("forward slot in receiver mode");
   chk_ret_rxonly: assert property (AUDIO_TRANSMITTER_MODE && $past(AUDIO_TRANSMITTER_MODE) |->
      !RET_SLOT.valid) else $error("return slot in transmitter mode");
   chk_frame_min: assert property (FRAME_START && seen_reg |-> gap_reg >= 17'h10428) else $error("frame short");
   chk_frame_max: assert property (seen_reg |-> gap_reg <= 17'h18704) else $error("frame overdue");
   chk_resend_seq: assert property (RESEND_REQ |-> resend_once) else $error("resend wrong");
   chk_conceal_run: assert property ($rose(CONCEAL) |-> run_reg >= 3'h3) else $error("early conceal");
   chk_ban_run: assert property ($changed(CHAN_BANNED) && CHAN_BANNED != '0 |-> run_reg >= 3'h4)
      else $error("early ban");
   chk_relink_drop: assert property (RELINK |=> !RELINK && !LINK_UP) else $error("relink wrong");
   chk_err_data: assert property (RET_SLOT.valid && RET_CLASS == SDF_RC_LINK_ERR && $past(LINK_ERR_IN.valid)
      |-> RET_SLOT.data == $past(LINK_ERR_IN.data)) else $error("error byte wrong");
   chk_pin_data: assert property (RET_SLOT.valid && RET_CLASS == SDF_RC_PIN_STATE
      |-> RET_SLOT.data == {4'h0, $past(PIN_STATE_IN)}) else $error("pin byte wrong");
endmodule
bind sdf_framer sdf_framer_chk #(.SRC_COUNT(SRC_COUNT), .FIFO_DEPTH_LOG2(FIFO_DEPTH_LOG2)) u_chk (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AUDIO_TRANSMITTER_MODE(AUDIO_TRANSMITTER_MODE),
   .AUDIO_FUNDAMENTAL_RATE(AUDIO_FUNDAMENTAL_RATE), .SRC_VALID(SRC_VALID), .SRC_DATA(SRC_DATA),
   .SRC_READY(SRC_READY), .FWD_SLOT(FWD_SLOT), .FRAME_START(FRAME_START), .LINK_ERR_IN(LINK_ERR_IN),
   .PIN_STATE_IN(PIN_STATE_IN), .MASTER_IN(MASTER_IN), .MASTER_READY(MASTER_READY), .RET_SLOT(RET_SLOT),
   .RET_CLASS(RET_CLASS), .AUDIO_RX(AUDIO_RX), .RESEND_REQ(RESEND_REQ), .RESEND_SEQ(RESEND_SEQ),
   .CONCEAL(CONCEAL), .CHANNEL(CHANNEL), .CHAN_BANNED(CHAN_BANNED), .LINK_UP(LINK_UP), .RELINK(RELINK)
);
`default_nettype wire

//--- dv/sdf_framer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sdf_framer_bench;
   import sdf_pkg::*;
   typedef struct packed {
      sdf_rate_e rate;
      logic src;
      logic [7:0] data;
   } sdf_row_s;
   // ----
   // Forward rows: rate in force for the slot, source, byte
   // ----
   localparam sdf_row_s ROWS [4] = '{'{SDF_RATE_48K, 1'b0, 8'hA5}, '{SDF_RATE_48K, 1'b1, 8'h3C},
      '{SDF_RATE_44K1, 1'b0, 8'h0F}, '{SDF_RATE_32K, 1'b1, 8'hF0}};
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic tx_mode = 1'b1;
   sdf_rate_e rate = SDF_RATE_48K;
   logic [1:0] src_valid = 2'h0;
   logic [15:0] src_data = 16'h0;
   sdf_byte_s err_in = 9'h0;
   sdf_byte_s master_in = 9'h0;
   logic [3:0] pin_in = 4'h0;
   logic pk_send = 1'b0;
   logic pk_ok = 1'b0;
   logic [5:0] pk_seq = 6'h0;
   logic [3:0] pk_lag = 4'h0;
   logic [1:0] src_ready;
   sdf_byte_s fwd_slot, ret_slot;
   sdf_class_e ret_class;
   sdf_audio_s audio_rx;
   logic frame_start, master_ready, resend_req, conceal, link_up, relink;
   logic [5:0] resend_seq, channel, rs_seq;
   logic [CHAN_COUNT-1:0] banned;
   int cyc, failures, check_count, rs_n, mr_n;
   int fs_q[$];
   sdf_framer #(.SRC_COUNT(2), .FIFO_DEPTH_LOG2(4)) dut (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AUDIO_TRANSMITTER_MODE(tx_mode), .AUDIO_FUNDAMENTAL_RATE(rate),
      .SRC_VALID(src_valid), .SRC_DATA(src_data), .SRC_READY(src_ready), .FWD_SLOT(fwd_slot),
      .FRAME_START(frame_start), .LINK_ERR_IN(err_in), .PIN_STATE_IN(pin_in), .MASTER_IN(master_in),
      .MASTER_READY(master_ready), .RET_SLOT(ret_slot), .RET_CLASS(ret_class), .AUDIO_RX(audio_rx),
      .RESEND_REQ(resend_req), .RESEND_SEQ(resend_seq), .CONCEAL(conceal), .CHANNEL(channel),
      .CHAN_BANNED(banned), .LINK_UP(link_up), .RELINK(relink)
   );
   sdf_peer peer (.clk(clk_sys), .rst(sys_rst), .send(pk_send), .seq(pk_seq), .ok(pk_ok), .lag(pk_lag),
      .audio_rx(audio_rx));
   initial forever #20 clk_sys = ~clk_sys;
   // ----
   // Monitors and run limit
   // ----
   always @(posedge clk_sys) begin
      cyc++;
      if (frame_start === 1'b1) fs_q.push_back(cyc);
      if (resend_req === 1'b1) begin
         rs_n++;
         rs_seq = resend_seq;
      end
      if (master_ready === 1'b1) mr_n++;
      if (cyc == 100000) begin
         failures++;
         final_report;
      end
   end
   task automatic final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp);
      check_count++;
      if (got < exp - 4 || got > exp + 4) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic int inc_of(input sdf_rate_e r);
      case (r)
         SDF_RATE_44K1: return int'(NCO_INC_44K1);
         SDF_RATE_32K: return int'(NCO_INC_32K);
         default: return int'(NCO_INC_48K);
      endcase
   endfunction
   task automatic push(input int s, input logic [7:0] d, output int ok);
      ok = 0;
      src_valid[s] <= 1'b1;
      src_data[s*8+:8] <= d;
      for (int n = 0; n < 4 && ok == 0; n++) begin
         @(posedge clk_sys);
         ok = int'(src_ready[s] === 1'b1);
      end
      src_valid[s] <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wait_slot(input logic ret, output sdf_byte_s b, output sdf_class_e c, output int at);
      for (int n = 0; n < 30000; n++) begin
         @(posedge clk_sys);
         if ((ret ? ret_slot.valid : fwd_slot.valid) === 1'b1) break;
      end
      b = ret ? ret_slot : fwd_slot;
      c = ret_class;
      at = cyc;
   endtask
   task automatic pkt(input logic [5:0] s, input logic good, input logic [3:0] lag);
      pk_send <= 1'b1;
      pk_seq <= s;
      pk_ok <= good;
      pk_lag <= lag;
      @(posedge clk_sys);
      pk_send <= 1'b0;
      repeat (30) @(posedge clk_sys);
   endtask
   initial begin
      int t[4];
      int acc, ok, hits, win;
      logic [5:0] ch;
      sdf_byte_s b;
      sdf_class_e c;
      sdf_class_e want[5];
      want = '{SDF_RC_LINK_ERR, SDF_RC_PIN_STATE, SDF_RC_MASTER, SDF_RC_IDLE, SDF_RC_IDLE};
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      foreach (ROWS[i]) push(int'(ROWS[i].src), ROWS[i].data, ok);
      for (int i = 0; i < 4; i++) begin
         wait_slot(1'b0, b, c, t[i]);
         cmp(b, {1'b1, ROWS[i].data});
         if (i > 0) near(t[i] - t[i-1], 32 * 2 ** 24 / inc_of(ROWS[i].rate));
         if (i < 3) rate <= ROWS[i+1].rate;
      end
      while (fs_q.size() == 0) @(posedge clk_sys);
      win = 0;
      foreach (fs_q[k]) win += int'(fs_q[k] <= t[3]);
      hits = fs_q[0] - t[3];
      cmp(win, 0);
      near(hits, 31 * 2 ** 24 / inc_of(SDF_RATE_32K));
      acc = 0;
      for (int k = 0; k < 17; k++) begin
         push(k % 2, 8'(k), ok);
         acc += ok;
      end
      cmp(acc, 16);
      sys_rst <= 1'b1;
      tx_mode <= 1'b0;
      rate <= SDF_RATE_48K;
      err_in <= {1'b1, 8'h5A};
      master_in <= {1'b1, 8'hC3};
      pin_in <= 4'hA;
      @(posedge clk_sys);
      cmp({fwd_slot, ret_slot, frame_start, resend_req, conceal, link_up, relink, banned}, 64'h0);
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wait_slot(1'b1, b, c, t[0]);
         if (i == 1 && c === SDF_RC_PIN_STATE) cmp(b.data, 8'h0A);
         if (i == 1 && c === SDF_RC_IDLE) c = SDF_RC_PIN_STATE;
         cmp(c, want[i]);
         if (i == 0) cmp(b.data, 8'h5A);
         if (i == 2) cmp(b.data, 8'hC3);
      end
      cmp(mr_n, 1);
      master_in.valid <= 1'b0;
      pkt(6'h01, 1'b1, 4'h0);
      pkt(6'h07, 1'b0, 4'h9);
      pkt(6'h07, 1'b0, 4'h0);
      cmp(rs_n, 2);
      cmp(rs_seq, 6'h02);
      pkt(6'h07, 1'b0, 4'h3);
      cmp(conceal, 1'b1);
      ch = channel;
      pkt(6'h08, 1'b0, 4'h0);
      cmp(banned[ch], 1'b1);
      final_report;
   end
endmodule
`default_nettype wire
